// >>> rtl/irq_wdt_pkg.sv
// constants and carrier types for the interrupt and watchdog unit
// assumes one 125 MHz clock and an AXI4-Lite master with 32-bit data
package irq_wdt_pkg;

  localparam int NUM_SRC = 11;
  localparam int NUM_PINS = 14;

  // source bit positions, identical in the enable and flag registers
  localparam int SRC_TIMER0 = 0;
  localparam int SRC_TIMER1 = 1;
  localparam int SRC_TIMER2 = 2;
  localparam int SRC_TIMER3 = 3;
  localparam int SRC_PIN_CHANGE = 4;
  localparam int SRC_EXT0 = 5;
  localparam int SRC_WDT = 6;
  localparam int SRC_EXT1 = 7;
  localparam int SRC_LOW_VOLTAGE = 8;
  localparam int SRC_COMPARATOR = 9;
  localparam int SRC_CONVERSION = 10;

  // pin vector: port a on 7:0, port b on 13:8
  localparam int PIN_PB0 = 8;
  localparam int PIN_PB1 = 9;

  localparam logic [10:0] VEC_TRAP = 11'h001;
  localparam logic [10:0] VEC_HW = 11'h008;

  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_FLAG = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_WAKE = 8'h10;
  localparam logic [7:0] ADDR_EXT = 8'h14;
  localparam logic [7:0] ADDR_OSC = 8'h18;

  // power control register fields
  localparam int PWR_RATIO_LSB = 0;
  localparam int PWR_PS_WDT_BIT = 3;
  localparam int PWR_WDT_RUN_BIT = 7;
  localparam logic [7:0] PWR_RESET = 8'h80;
  // status register fields
  localparam int STAT_EOC_BIT = 0;
  localparam int STAT_TIMEOUT_BIT = 4;
  // external select register fields
  localparam int EXT0_SEL_BIT = 0;
  localparam int EXT1_SEL_BIT = 1;
  localparam int EXT_EDGE_BIT = 2;
  // osc control register: live comparator output
  localparam int OSC_CMP_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // watchdog oscillator rate and base periods
  localparam int WDT_TICK_KHZ = 64;
  localparam int WDT_PERIOD0_US = 3500;
  localparam int WDT_PERIOD1_US = 15000;
  localparam int WDT_PERIOD2_US = 60000;
  localparam int WDT_PERIOD3_US = 250000;
  localparam int WDT_TICKS0 = WDT_PERIOD0_US * WDT_TICK_KHZ / 1000;
  localparam int WDT_TICKS1 = WDT_PERIOD1_US * WDT_TICK_KHZ / 1000;
  localparam int WDT_TICKS2 = WDT_PERIOD2_US * WDT_TICK_KHZ / 1000;
  localparam int WDT_TICKS3 = WDT_PERIOD3_US * WDT_TICK_KHZ / 1000;

  typedef struct packed {
    logic trap;
    logic ret;
    logic irq_on;
    logic irq_off;
    logic wdt_clear;
  } core_op_t;

  typedef struct packed {
    logic enable;
    logic irq_mode;
    logic [1:0] period;
  } wdt_cfg_t;

endpackage

// >>> rtl/irq_wdt_unit.sv
// interrupt collection, vectoring, global enable and watchdog timer
// assumes opcode pulses from the core, event inputs synchronous to clock_in,
// watchdog oscillator delivered as a one-cycle tick, AXI4-Lite master
module irq_wdt_unit #(
  parameter int unsigned WDT_TICKS_P0 = irq_wdt_pkg::WDT_TICKS0,
  parameter int unsigned WDT_TICKS_P1 = irq_wdt_pkg::WDT_TICKS1,
  parameter int unsigned WDT_TICKS_P2 = irq_wdt_pkg::WDT_TICKS2,
  parameter int unsigned WDT_TICKS_P3 = irq_wdt_pkg::WDT_TICKS3
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire irq_wdt_pkg::core_op_t op_in,
  input wire irq_wdt_pkg::wdt_cfg_t wdt_cfg_in,
  input wire logic wdt_tick_in,
  input wire logic timer0_wrap_in,
  input wire logic [2:0] timer_underflow_in,
  input wire logic [13:0] pins_in,
  input wire logic [13:0] pin_is_input_in,
  input wire logic low_voltage_in,
  input wire logic comparator_in,
  input wire logic conversion_done_in,
  output logic vector_req_out,
  output logic [10:0] vector_addr_out,
  output logic global_irq_enable_out,
  output logic chip_reset_out,
  output logic timeout_flag_out
);
  import irq_wdt_pkg::*;

  localparam logic [17:0] LIMIT0 = 18'(WDT_TICKS_P0);
  localparam logic [17:0] LIMIT1 = 18'(WDT_TICKS_P1);
  localparam logic [17:0] LIMIT2 = 18'(WDT_TICKS_P2);
  localparam logic [17:0] LIMIT3 = 18'(WDT_TICKS_P3);

  // register state
  logic [10:0] irq_en;
  logic [10:0] flags;
  logic [7:0] power_ctl;
  logic [13:0] wake_select;
  logic [2:0] ext_cfg;
  logic global_irq_enable;
  logic timeout_flag;
  // bus state
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // event history
  logic hist_valid;
  logic [13:0] prev_pins;
  logic prev_low_voltage;
  logic prev_done;
  logic cmp_latched;
  logic cmp_seen;
  // watchdog
  logic [17:0] base_cnt;
  logic [7:0] pre_cnt;

  // AXI4-Lite handshakes
  wire aw_take = awvalid_in & awready_out;
  wire w_take = wvalid_in & wready_out;
  wire ar_take = arvalid_in & arready_out;
  wire wr_fire = aw_full & w_full & ~bvalid_out;
  wire next_aw_full = wr_fire ? 1'b0 : (aw_full | aw_take);
  wire next_w_full = wr_fire ? 1'b0 : (w_full | w_take);
  wire next_bvalid = wr_fire | (bvalid_out & ~bready_in);
  wire next_rvalid = ar_take | (rvalid_out & ~rready_in);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;
  wire [31:0] wkeep = ~wmask;

  // write decode
  wire wr_enable = wr_fire & (aw_addr == ADDR_ENABLE);
  wire wr_flag = wr_fire & (aw_addr == ADDR_FLAG);
  wire wr_power = wr_fire & (aw_addr == ADDR_POWER);
  wire wr_wake = wr_fire & (aw_addr == ADDR_WAKE);
  wire wr_ext = wr_fire & (aw_addr == ADDR_EXT);
  wire wr_hit = (aw_addr == ADDR_ENABLE) | (aw_addr == ADDR_FLAG) | (aw_addr == ADDR_POWER) |
                (aw_addr == ADDR_STATUS) | (aw_addr == ADDR_WAKE) | (aw_addr == ADDR_EXT) |
                (aw_addr == ADDR_OSC);

  // read decode
  wire [10:0] flag_view = flags & irq_en;
  wire sel_enable = araddr_in == ADDR_ENABLE;
  wire sel_flag = araddr_in == ADDR_FLAG;
  wire sel_power = araddr_in == ADDR_POWER;
  wire sel_status = araddr_in == ADDR_STATUS;
  wire sel_wake = araddr_in == ADDR_WAKE;
  wire sel_ext = araddr_in == ADDR_EXT;
  wire sel_osc = araddr_in == ADDR_OSC;
  wire rd_hit = sel_enable | sel_flag | sel_power | sel_status | sel_wake | sel_ext | sel_osc;
  wire [31:0] status_word = (32'(timeout_flag) << STAT_TIMEOUT_BIT) |
                            (32'(conversion_done_in) << STAT_EOC_BIT);
  wire [31:0] rd_word = sel_enable ? {21'h0, irq_en} :
                        sel_flag ? {21'h0, flag_view} :
                        sel_power ? {24'h0, power_ctl} :
                        sel_status ? status_word :
                        sel_wake ? {18'h0, wake_select} :
                        sel_ext ? {29'h0, ext_cfg} :
                        sel_osc ? (32'(comparator_in) << OSC_CMP_BIT) : 32'h0;
  wire osc_read = ar_take & sel_osc;

  // pin change and external edges
  wire ext0_sel = ext_cfg[EXT0_SEL_BIT];
  wire ext1_sel = ext_cfg[EXT1_SEL_BIT];
  wire edge_polarity = ext_cfg[EXT_EDGE_BIT];
  wire [13:0] ext_block = (14'(ext0_sel) << PIN_PB0) | (14'(ext1_sel) << PIN_PB1);
  wire [13:0] change_mask = wake_select & pin_is_input_in & ~ext_block;
  wire pin_change_evt = hist_valid & (|((pins_in ^ prev_pins) & change_mask));
  wire pb0_rise = pins_in[PIN_PB0] & ~prev_pins[PIN_PB0];
  wire pb0_fall = ~pins_in[PIN_PB0] & prev_pins[PIN_PB0];
  wire pb1_rise = pins_in[PIN_PB1] & ~prev_pins[PIN_PB1];
  wire pb1_fall = ~pins_in[PIN_PB1] & prev_pins[PIN_PB1];
  wire ext0_evt = hist_valid & ext0_sel & (edge_polarity ? pb0_rise : pb0_fall);
  wire ext1_evt = hist_valid & ext1_sel & (edge_polarity ? pb1_rise : pb1_fall);
  wire low_voltage_evt = hist_valid & prev_low_voltage & ~low_voltage_in;
  // one event per mismatch; a read of the osc register rearms the detector
  wire cmp_evt = (comparator_in != cmp_latched) & ~cmp_seen;
  wire done_evt = hist_valid & conversion_done_in & ~prev_done;

  // watchdog
  wire wdt_active = wdt_cfg_in.enable & power_ctl[PWR_WDT_RUN_BIT];
  wire ps_routed = power_ctl[PWR_PS_WDT_BIT];
  wire [2:0] ratio = power_ctl[PWR_RATIO_LSB +: 3];
  wire [17:0] base_limit = (wdt_cfg_in.period == 2'd0) ? LIMIT0 :
                           (wdt_cfg_in.period == 2'd1) ? LIMIT1 :
                           (wdt_cfg_in.period == 2'd2) ? LIMIT2 : LIMIT3;
  // ticks are counted whatever the core's operating mode, so sleep never stops it
  wire base_wrap = wdt_active & wdt_tick_in & (base_cnt == base_limit - 18'd1);
  // with the prescaler routed, interrupt mode divides by one extra power of two
  wire [3:0] div_log = {1'b0, ratio} + {3'b0, wdt_cfg_in.irq_mode};
  wire [8:0] div_last = (9'h1 << div_log) - 9'h1;
  wire pre_last = {1'b0, pre_cnt} == div_last;
  wire wdt_expire = base_wrap & (~ps_routed | pre_last);
  wire wdt_evt = wdt_expire & wdt_cfg_in.irq_mode;
  wire wdt_clr_routed = op_in.wdt_clear & ps_routed;

  // sources at fixed positions
  wire [10:0] events = (11'(timer0_wrap_in) << SRC_TIMER0) |
                       (11'(timer_underflow_in[0]) << SRC_TIMER1) |
                       (11'(timer_underflow_in[1]) << SRC_TIMER2) |
                       (11'(timer_underflow_in[2]) << SRC_TIMER3) |
                       (11'(pin_change_evt) << SRC_PIN_CHANGE) |
                       (11'(ext0_evt) << SRC_EXT0) |
                       (11'(wdt_evt) << SRC_WDT) |
                       (11'(ext1_evt) << SRC_EXT1) |
                       (11'(low_voltage_evt) << SRC_LOW_VOLTAGE) |
                       (11'(cmp_evt) << SRC_COMPARATOR) |
                       (11'(done_evt) << SRC_CONVERSION);
  // only written zeros clear; an event in the same cycle wins
  wire [10:0] flag_clear = wr_flag ? (wmask[10:0] & ~w_data[10:0]) : 11'h0;
  wire [10:0] next_flags = (flags & ~flag_clear) | events;

  // vectoring; pending requests wait for the global enable
  wire hw_req = (|(flags & irq_en)) & global_irq_enable;
  wire take_vector = op_in.trap | hw_req;
  wire next_gie = take_vector ? 1'b0 :
                  (op_in.ret | op_in.irq_on) ? 1'b1 :
                  op_in.irq_off ? 1'b0 : global_irq_enable;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rresp_out <= RESP_OKAY;
      rdata_out <= 32'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready_out <= ~next_aw_full & ~next_bvalid;
      wready_out <= ~next_w_full & ~next_bvalid;
      bvalid_out <= next_bvalid;
      arready_out <= ~next_rvalid;
      rvalid_out <= next_rvalid;
      if (wr_fire) begin
        bresp_out <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (ar_take) begin
        rdata_out <= rd_word;
        rresp_out <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (aw_take) begin
      aw_addr <= awaddr_in;
    end
    if (w_take) begin
      w_data <= wdata_in;
      w_strb <= wstrb_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_en <= 11'h0;
      flags <= 11'h0;
      power_ctl <= PWR_RESET;
      wake_select <= 14'h0;
      ext_cfg <= 3'h0;
    end else begin
      flags <= next_flags;
      if (wr_enable) begin
        irq_en <= (irq_en & wkeep[10:0]) | wbits[10:0];
      end
      if (wr_power) begin
        power_ctl <= (power_ctl & wkeep[7:0]) | wbits[7:0];
      end
      if (wr_wake) begin
        wake_select <= (wake_select & wkeep[13:0]) | wbits[13:0];
      end
      if (wr_ext) begin
        ext_cfg <= (ext_cfg & wkeep[2:0]) | wbits[2:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hist_valid <= 1'b0;
      prev_pins <= 14'h0;
      prev_low_voltage <= 1'b0;
      prev_done <= 1'b0;
      cmp_latched <= 1'b0;
      cmp_seen <= 1'b1;
    end else begin
      hist_valid <= 1'b1;
      prev_pins <= pins_in;
      prev_low_voltage <= low_voltage_in;
      prev_done <= conversion_done_in;
      if (osc_read) begin
        cmp_latched <= comparator_in;
        cmp_seen <= 1'b0;
      end else if (cmp_evt) begin
        cmp_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      base_cnt <= 18'h0;
      pre_cnt <= 8'h0;
      timeout_flag <= 1'b1;
      chip_reset_out <= 1'b0;
    end else begin
      chip_reset_out <= wdt_expire & ~wdt_cfg_in.irq_mode;
      // every base wrap restarts the count, or a divided period would never end
      if (op_in.wdt_clear | base_wrap | ~wdt_active) begin
        base_cnt <= 18'h0;
      end else if (wdt_tick_in) begin
        base_cnt <= base_cnt + 18'd1;
      end
      if (wdt_clr_routed | wdt_expire | ~wdt_active) begin
        pre_cnt <= 8'h0;
      end else if (base_wrap) begin
        pre_cnt <= pre_cnt + 8'd1;
      end
      // expiry outranks a clear landing in the same cycle
      if (wdt_expire) begin
        timeout_flag <= 1'b0;
      end else if (wdt_clr_routed) begin
        timeout_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      global_irq_enable <= 1'b0;
      vector_req_out <= 1'b0;
      vector_addr_out <= 11'h0;
    end else begin
      global_irq_enable <= next_gie;
      vector_req_out <= take_vector;
      if (take_vector) begin
        vector_addr_out <= op_in.trap ? VEC_TRAP : VEC_HW;
      end
    end
  end

  assign global_irq_enable_out = global_irq_enable;
  assign timeout_flag_out = timeout_flag;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  trap_vector_a: assert property (op_in.trap
    |=> vector_req_out && vector_addr_out == VEC_TRAP)
    else $error("trap did not vector to the trap address");
  trap_gie_a: assert property (op_in.trap |=> !global_irq_enable_out)
    else $error("global enable still set after trap");
  ret_gie_a: assert property (op_in.ret && !take_vector |=> global_irq_enable_out)
    else $error("return opcode did not set global enable");
  hw_gate_a: assert property (vector_req_out && vector_addr_out == VEC_HW
    && !$past(op_in.trap) |-> $past(global_irq_enable) && !global_irq_enable)
    else $error("hardware vector without global enable");
  flag_sticky_a: assert property ((|($past(flags) & ~flags)) |-> $past(wr_flag))
    else $error("flag dropped without a write of zero");
  flag_read_a: assert property (ar_take && sel_flag
    |=> rdata_out[10:0] == ($past(flags) & $past(irq_en)))
    else $error("flag read not masked by its enable");
  // a second pulse right after the vector may only come from a trap
  hw_vector_a: assert property (hw_req && !op_in.trap
    |=> vector_req_out && vector_addr_out == VEC_HW ##1 (!vector_req_out || $past(op_in.trap)))
    else $error("enabled pending flag not vectored");
  pending_a: assert property ((|(flags & irq_en)) && !global_irq_enable
    && op_in.irq_on && !op_in.trap && !op_in.irq_off && !wr_flag && !wr_enable
    |=> ##1 vector_req_out)
    else $error("held request not vectored after enable returned");
  expire_flag_a: assert property (wdt_expire
    |=> !timeout_flag_out && chip_reset_out == !$past(wdt_cfg_in.irq_mode))
    else $error("watchdog expiry effects missing");
  wdt_clear_a: assert property (wdt_clr_routed && !wdt_expire
    |=> timeout_flag_out && base_cnt == 18'h0 && pre_cnt == 8'h0)
    else $error("clear opcode did not restart watchdog");
  wdt_irq_a: assert property (wdt_expire && wdt_cfg_in.irq_mode |=> flags[SRC_WDT])
    else $error("watchdog interrupt flag not set");

endmodule // irq_wdt_unit

// >>> tb/core_model.sv
// behavioural core sequencer: replays opcode requests, records fetch redirects
// assumes the unit's clock, synchronous reset and opcode and vector ports
module core_model (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire irq_wdt_pkg::core_op_t op_req_in,
  input wire logic vector_req_in,
  input wire logic [10:0] vector_addr_in,
  output irq_wdt_pkg::core_op_t op_out,
  output logic fetch_seen_out,
  output logic [10:0] fetch_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_wdt_pkg::*;
  core_op_t held;
  // a return right after irq_on could drop a pending flag, so it waits a cycle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      op_out <= '0;
      held <= '0;
    end else if (op_out.irq_on && op_req_in.ret) begin
      op_out <= '0;
      held <= op_req_in;
    end else begin
      op_out <= op_req_in | held;
      held <= '0;
    end
  end
  always_ff @(posedge clock_in) begin
    fetch_seen_out <= vector_req_in & ~srst_in;
    fetch_addr_out <= vector_addr_in;
  end
endmodule // core_model

// >>> tb/interrupt_and_watchdog_unit_tb.sv
// self-checking bench for the interrupt and watchdog unit
// assumes irq_wdt_pkg, irq_wdt_unit and core_model are compiled first
module interrupt_and_watchdog_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_wdt_pkg::*;
  localparam core_op_t OP_TRAP = 5'h10;
  localparam core_op_t OP_RET = 5'h08;
  localparam core_op_t OP_ON = 5'h04;
  localparam core_op_t OP_OFF = 5'h02;
  localparam core_op_t OP_CLR = 5'h01;
  logic clock_in, srst_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic [7:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, r;
  logic [3:0] wstrb_in;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, tick_cnt;
  core_op_t op_req, op_in;
  wdt_cfg_t wdt_cfg_in;
  logic wdt_tick_in, timer0_wrap_in, low_voltage_in, comparator_in, conversion_done_in;
  logic [2:0] timer_underflow_in;
  logic [13:0] pins_in, pin_is_input_in;
  logic vector_req_out, chip_reset_out, global_irq_enable_out, timeout_flag_out, fetch_seen;
  logic [10:0] vector_addr_out, fetch_addr;
  logic [33:0] rd_q[$];
  logic [11:0] ev_q[$];
  logic [1:0] wr_q[$];
  int err_total, checked;

  irq_wdt_unit #(.WDT_TICKS_P0(4), .WDT_TICKS_P1(5), .WDT_TICKS_P2(6), .WDT_TICKS_P3(8)) DUT (
    .clock_in, .srst_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in,
    .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
    .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in, .op_in, .wdt_cfg_in,
    .wdt_tick_in, .timer0_wrap_in, .timer_underflow_in, .pins_in, .pin_is_input_in,
    .low_voltage_in, .comparator_in, .conversion_done_in, .vector_req_out,
    .vector_addr_out, .global_irq_enable_out, .chip_reset_out, .timeout_flag_out);
  core_model model (.clock_in, .srst_in, .op_req_in(op_req), .vector_req_in(vector_req_out),
    .vector_addr_in(vector_addr_out), .op_out(op_in), .fetch_seen_out(fetch_seen),
    .fetch_addr_out(fetch_addr));

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // free-running watchdog oscillator, one tick every four clocks
  always @(posedge clock_in) begin
    tick_cnt <= tick_cnt + 2'd1;
    wdt_tick_in <= (tick_cnt == 2'd3);
  end

  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rsp = RESP_OKAY);
    wr_q.push_back(rsp);
    @(posedge clock_in);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (!bvalid_out);
    bready_in <= 1'b0;
  endtask
  // read data is judged by the watcher against the queued note
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    @(posedge clock_in);
    rd_q.push_back(exp);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do @(posedge clock_in); while (!arready_out);
    arvalid_in <= 1'b0;
    do @(posedge clock_in); while (!rvalid_out);
    rready_in <= 1'b0;
  endtask
  task automatic op(input core_op_t v);
    @(posedge clock_in);
    op_req <= v;
    @(posedge clock_in);
    op_req <= '0;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic fire(input int i);
    int k;
    k = $urandom_range(7);
    @(posedge clock_in);
    case (i)
      SRC_TIMER0: timer0_wrap_in <= 1'b1;
      SRC_TIMER1, SRC_TIMER2, SRC_TIMER3: timer_underflow_in[i-1] <= 1'b1;
      SRC_PIN_CHANGE: pins_in[k] <= ~pins_in[k];
      SRC_EXT0: pins_in[PIN_PB0] <= 1'b1;
      SRC_EXT1: pins_in[PIN_PB1] <= 1'b1;
      SRC_LOW_VOLTAGE: low_voltage_in <= 1'b0;
      SRC_COMPARATOR: comparator_in <= 1'b1;
      default: conversion_done_in <= 1'b1;
    endcase
    @(posedge clock_in);
    timer0_wrap_in <= 1'b0;
    timer_underflow_in <= 3'h0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    if (rvalid_out && rready_in) begin
      check("read", rd_q.size() ? rd_q.pop_front() : 'x, {rresp_out, rdata_out});
    end
    if (bvalid_out && bready_in) begin
      check("write response", wr_q.size() ? wr_q.pop_front() : 'x, bresp_out);
    end
    if (fetch_seen) begin
      check("fetch", ev_q.size() ? ev_q.pop_front() : 'x, {1'b0, fetch_addr});
    end
    if (chip_reset_out) begin
      check("chip reset", ev_q.size() ? ev_q.pop_front() : 'x, 12'h800);
    end
  end
  initial begin
    #100000;
    err_total++;
    $display("unexpected hang: expected finish, seen timeout");
    wrap_up();
  end

  initial begin
    void'($urandom(38));
    {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} <= 5'h0;
    {awaddr_in, araddr_in, wdata_in} <= 48'h0;
    wstrb_in <= 4'hf;
    {op_req, wdt_cfg_in, tick_cnt, wdt_tick_in, timer0_wrap_in} <= 13'h0;
    {timer_underflow_in, comparator_in, conversion_done_in, pins_in} <= 19'h0;
    low_voltage_in <= 1'b1;
    pin_is_input_in <= 14'h3fff;
    srst_in <= 1'b1;
    wait_clk(5);
    srst_in <= 1'b0;
    @(posedge clock_in);
    check("gie", 1'b0, global_irq_enable_out);
    check("timeout flag", 1'b1, timeout_flag_out);
    rd(ADDR_ENABLE, 34'h0);
    rd(ADDR_POWER, {RESP_OKAY, 24'h0, PWR_RESET});
    rd(ADDR_STATUS, 34'h10);
    rd(8'h1c, {RESP_DECERR, 32'h0});
    wr(8'h1c, 32'hffff_ffff, RESP_DECERR);
    r = $urandom;
    wr(ADDR_ENABLE, r);
    rd(ADDR_ENABLE, {23'h0, r[10:0]});
    rd(ADDR_OSC, 34'h0);
    $display("test registers done");
    ev_q.push_back({1'b0, VEC_TRAP});
    op(OP_TRAP);
    wait_clk(2);
    check("gie", 1'b0, global_irq_enable_out);
    op(OP_RET);
    wait_clk(2);
    check("gie", 1'b1, global_irq_enable_out);
    ev_q.push_back({1'b0, VEC_TRAP});
    op(OP_TRAP);
    wait_clk(2);
    check("gie", 1'b0, global_irq_enable_out);
    op(OP_ON);
    op(OP_OFF);
    wait_clk(2);
    check("gie", 1'b0, global_irq_enable_out);
    $display("test traps done");
    wr(ADDR_WAKE, 32'h3fff);
    wr(ADDR_EXT, 32'h7);
    wr(ADDR_ENABLE, 32'h7ff);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == SRC_WDT) continue;
      op(OP_ON);
      ev_q.push_back({1'b0, VEC_HW});
      fire(i);
      wait_clk(4);
      check("gie", 1'b0, global_irq_enable_out);
      rd(ADDR_FLAG, 34'h1 << i);
      wr(ADDR_FLAG, 32'h0);
      rd(ADDR_FLAG, 34'h0);
    end
    // port a pins turned to outputs must not report a level change
    pin_is_input_in <= 14'h3f00;
    fire(SRC_PIN_CHANGE);
    wait_clk(4);
    rd(ADDR_FLAG, 34'h0);
    pin_is_input_in <= 14'h3fff;
    wr(ADDR_EXT, 32'h3);
    op(OP_ON);
    ev_q.push_back({1'b0, VEC_HW});
    pins_in[PIN_PB0] <= 1'b0;
    wait_clk(4);
    rd(ADDR_FLAG, 34'h20);
    wr(ADDR_FLAG, 32'h0);
    rd(ADDR_STATUS, 34'h11);
    wr(ADDR_ENABLE, 32'h0);
    op(OP_ON);
    fire(SRC_TIMER0);
    wait_clk(4);
    rd(ADDR_FLAG, 34'h0);
    op(OP_OFF);
    wr(ADDR_ENABLE, 32'h1);
    rd(ADDR_FLAG, 34'h1);
    ev_q.push_back({1'b0, VEC_HW});
    op(OP_ON);
    wait_clk(4);
    wr(ADDR_FLAG, 32'h0);
    $display("test sources done");
    wr(ADDR_ENABLE, 32'h40);
    wr(ADDR_POWER, 32'h0);
    wdt_cfg_in <= 4'hc;
    op(OP_ON);
    wait_clk(40);
    check("timeout flag", 1'b1, timeout_flag_out);
    ev_q.push_back({1'b0, VEC_HW});
    wr(ADDR_POWER, 32'h80);
    wait_clk(40);
    check("timeout flag", 1'b0, timeout_flag_out);
    rd(ADDR_FLAG, 34'h40);
    wdt_cfg_in <= 4'h4;
    wr(ADDR_FLAG, 32'h0);
    wr(ADDR_POWER, 32'h88);
    wdt_cfg_in <= 4'h8;
    op(OP_CLR);
    wait_clk(2);
    check("timeout flag", 1'b1, timeout_flag_out);
    ev_q.push_back(12'h800);
    do @(posedge clock_in); while (!chip_reset_out);
    wdt_cfg_in <= 4'h0;
    wait_clk(2);
    check("timeout flag", 1'b0, timeout_flag_out);
    // routed, ratio 1, interrupt mode, period 1: four base wraps of five ticks
    wr(ADDR_POWER, 32'h89);
    wdt_cfg_in <= 4'hd;
    op(OP_CLR);
    wait_clk(70);
    check("timeout flag", 1'b1, timeout_flag_out);
    wait_clk(30);
    check("timeout flag", 1'b0, timeout_flag_out);
    wdt_cfg_in <= 4'h0;
    check("pending", 34'h0, rd_q.size() + ev_q.size() + wr_q.size());
    $display("test watchdog done");
    wrap_up();
  end
endmodule // interrupt_and_watchdog_unit_tb
